// ### data_memory_addressing_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module data_memory_addressing_unit_tb;
  import dmau_pkg::*;
  logic SYS_CLK = 1'b0, RST = 1'b1, WDT_PD_RESET = 1'b0, MEM_RD = 1'b0, MEM_WR = 1'b0;
  logic ALU_WR = 1'b0, PC_JUMP, STALL;
  logic [6:0] MEM_ADDR = 7'h00;
  logic [7:0] MEM_WDATA = 8'h00, ALU_RESULT = 8'h00, MEM_RDATA, ACCUMULATOR, BANK_SELECT;
  logic [7:0] NVM_CONTROL;
  logic [10:0] PC_CUR = 11'h523, TBL_ADDR, PC_TARGET;
  logic [13:0] PROG_WORD, w;
  logic [2:0] p;
  dmau_tbl_t TBL_OP = DMAU_TBL_NONE;
  int n_fail = 0, samples_checked = 0;
  always #5 SYS_CLK = ~SYS_CLK;
  dmau_core u_dut (.SYS_CLK, .RST, .WDT_PD_RESET, .MEM_RD, .MEM_WR, .MEM_ADDR, .MEM_WDATA,
    .MEM_RDATA, .ALU_WR, .ALU_RESULT, .PC_CUR, .TBL_OP, .PROG_WORD, .TBL_ADDR, .PC_JUMP,
    .PC_TARGET, .STALL, .ACCUMULATOR, .BANK_SELECT, .NVM_CONTROL);
  dmau_prog_rom u_rom (.addr(TBL_ADDR), .word(PROG_WORD));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge SYS_CLK) {MEM_WR, MEM_ADDR, MEM_WDATA} = {1'b1, a, d};
    @(negedge SYS_CLK) MEM_WR = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(negedge SYS_CLK) {MEM_RD, MEM_ADDR} = {1'b1, a};
    @(negedge SYS_CLK) MEM_RD = 1'b0;
    chk(MEM_RDATA, e);
  endtask
  task automatic finish_test();
    if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Nothing here waits on the design; this only cuts a stuck run
  initial begin
    #100000;
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (16) @(negedge SYS_CLK);
    RST = 1'b0;
    rd(7'h01, 8'h80);
    wr(7'h01, 8'h45);
    rd(7'h01, 8'hc5);
    wr(7'h40, 8'h5a);
    wr(7'h01, 8'h40);
    rd(7'h00, 8'h5a);
    wr(7'h01, 8'h41);
    wr(7'h00, 8'h33);
    rd(7'h41, 8'h33);
    wr(7'h01, 8'h02);
    wr(7'h00, 8'hee);
    rd(7'h00, 8'h00);
    rd(7'h0c, 8'h00);
    wr(7'h05, 8'h77);
    wr(7'h04, 8'h01);
    wr(7'h03, 8'h40);
    wr(7'h02, 8'h0d);
    chk(NVM_CONTROL, 8'h0d);
    rd(7'h02, 8'h0d);
    rd(7'h40, 8'h5a);
    wr(7'h03, 8'h05);
    rd(7'h02, 8'h77);
    wr(7'h01, 8'h41);
    rd(7'h00, 8'h33);
    @(negedge SYS_CLK) {RST, WDT_PD_RESET} = 2'b11;
    repeat (2) @(negedge SYS_CLK);
    chk(BANK_SELECT, 8'h01);
    {RST, WDT_PD_RESET} = 2'b10;
    @(negedge SYS_CLK) chk(BANK_SELECT, 8'h00);
    RST = 1'b0;
    @(negedge SYS_CLK) {ALU_WR, ALU_RESULT} = {1'b1, 8'h9c};
    @(negedge SYS_CLK) ALU_WR = 1'b0;
    rd(7'h05, 8'h9c);
    wr(7'h04, 8'h00);
    wr(7'h03, 8'h40);
    rd(7'h02, 8'h5a);
    @(negedge SYS_CLK) {MEM_WR, MEM_ADDR, MEM_WDATA} = {1'b1, 7'h06, 8'h10};
    #1 chk(PC_JUMP, 1'b1);
    chk(PC_TARGET, 11'h510);
    @(negedge SYS_CLK) MEM_WR = 1'b0;
    chk(STALL, 1'b1);
    wr(7'h07, 8'h34);
    for (int i = 1; i < 3; i++) begin
      p = (i == 1) ? 3'h5 : 3'h7;
      w = {p, p, 8'h34} ^ 14'h1a5c;
      @(negedge SYS_CLK) MEM_ADDR = 7'h48;
      TBL_OP = dmau_tbl_t'(i);
      #1 chk(TBL_ADDR, {p, 8'h34});
      @(negedge SYS_CLK) TBL_OP = DMAU_TBL_NONE;
      chk(STALL, 1'b1);
      wr(7'h08, 8'hff);
      rd(7'h08, {2'b00, w[13:8]});
      rd(7'h48, w[7:0]);
    end
    finish_test();
  end
endmodule
`default_nettype wire

// ### dmau_addr_map.sv
`timescale 1ns/1ps
`default_nettype none
// Resolves a direct or indirect access to a physical bank and location
module dmau_addr_map
  import dmau_pkg::*;
(
  input wire logic [6:0] addr,
  input wire logic [7:0] mptr_a,
  input wire logic [7:0] mptr_b,
  input wire logic [7:0] bank_select,
  output logic [6:0] eff_addr,
  output logic eff_bank1,
  output logic null_access
);
  wire via_a = (addr == DMAU_IWIN_A);
  wire via_b = (addr == DMAU_IWIN_B);
  wire [6:0] ptr_lo = via_a ? mptr_a[6:0] : mptr_b[6:0];
  wire indirect = via_a | via_b;
  // Bank one only through the second window; direct and first window stay bank zero
  wire bank1_req = via_b & (bank_select == DMAU_BANK1);
  assign eff_addr = indirect ? ptr_lo : addr;
  // Special register range never reaches bank one
  assign eff_bank1 = bank1_req & (eff_addr > DMAU_SFR_LAST);
  assign null_access = indirect & ((ptr_lo == DMAU_IWIN_A) | (ptr_lo == DMAU_IWIN_B));
endmodule
`default_nettype wire

// ### dmau_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dmau_chk
  import dmau_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic WDT_PD_RESET,
  // Requests
  input wire logic MEM_WR,
  input wire logic [6:0] MEM_ADDR,
  input wire logic [7:0] MEM_WDATA,
  input wire logic ALU_WR,
  input wire logic [7:0] ALU_RESULT,
  input wire logic [dmau_pkg::DMAU_PCW-1:0] PC_CUR,
  input wire dmau_pkg::dmau_tbl_t TBL_OP,
  // Results
  input wire logic [dmau_pkg::DMAU_PCW-1:0] TBL_ADDR,
  input wire logic PC_JUMP,
  input wire logic [dmau_pkg::DMAU_PCW-1:0] PC_TARGET,
  input wire logic STALL,
  input wire logic [7:0] ACCUMULATOR,
  input wire logic [7:0] BANK_SELECT
);
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  sequence s_pcl_wr;
    MEM_WR && MEM_ADDR == DMAU_PCLOW;
  endsequence
  sequence s_pcl_target;
    PC_JUMP && PC_TARGET == {PC_CUR[10:8], MEM_WDATA};
  endsequence
  sequence s_dummy;
    STALL ##1 !STALL;
  endsequence
  sequence s_tbl_cur;
    TBL_OP == DMAU_TBL_CUR;
  endsequence
  sequence s_cur_page;
    TBL_ADDR[10:8] == PC_CUR[10:8];
  endsequence
  sequence s_tbl_last;
    TBL_OP == DMAU_TBL_LAST;
  endsequence
  sequence s_last_page;
    TBL_ADDR[10:8] == DMAU_LAST_PAGE;
  endsequence
  sequence s_bank_wr;
    MEM_WR && MEM_ADDR == DMAU_BANKSEL;
  endsequence
  sequence s_cold_rst;
    RST && !WDT_PD_RESET;
  endsequence
  sequence s_wdt_rst;
    RST && WDT_PD_RESET;
  endsequence
  sequence s_bank0;
    BANK_SELECT == DMAU_BANK0;
  endsequence
  sequence s_bank_held;
    $stable(BANK_SELECT);
  endsequence
  AST_PCL_JUMP: assert property (s_pcl_wr |-> s_pcl_target)
    else $error("pcl jump wrong");
  AST_PCL_DUMMY: assert property (s_pcl_wr |=> s_dummy)
    else $error("pcl dummy cycle wrong");
  AST_TBL_TWO: assert property (TBL_OP != DMAU_TBL_NONE && !STALL |=> s_dummy)
    else $error("table op length wrong");
  AST_TBL_CUR: assert property (s_tbl_cur |-> s_cur_page)
    else $error("current page wrong");
  AST_TBL_LAST: assert property (s_tbl_last |-> s_last_page)
    else $error("last page wrong");
  AST_ALU_ACC: assert property (ALU_WR |=> ACCUMULATOR == $past(ALU_RESULT))
    else $error("alu result lost");
  AST_BANK_WR: assert property (s_bank_wr |=> BANK_SELECT == $past(MEM_WDATA))
    else $error("bank write lost");
  AST_BANK_RST: assert property (disable iff (1'b0) s_cold_rst |=> s_bank0)
    else $error("bank not reset");
  AST_BANK_KEEP: assert property (disable iff (1'b0) s_wdt_rst |=> s_bank_held)
    else $error("bank lost in power-down reset");
endmodule
bind dmau_core dmau_chk u_chk (.SYS_CLK, .RST, .WDT_PD_RESET, .MEM_WR, .MEM_ADDR, .MEM_WDATA,
  .ALU_WR, .ALU_RESULT, .PC_CUR, .TBL_OP, .TBL_ADDR, .PC_JUMP, .PC_TARGET, .STALL,
  .ACCUMULATOR, .BANK_SELECT);
`default_nettype wire

// ### dmau_core.sv
`timescale 1ns/1ps
`default_nettype none
module dmau_core
  import dmau_pkg::*;
#(
  parameter int GP_SIZE = 64
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic WDT_PD_RESET,
  // Data memory access from the core
  input wire logic MEM_RD,
  input wire logic MEM_WR,
  input wire logic [6:0] MEM_ADDR,
  input wire logic [7:0] MEM_WDATA,
  output logic [7:0] MEM_RDATA,
  // ALU result
  input wire logic ALU_WR,
  input wire logic [7:0] ALU_RESULT,
  // Program counter and table reads
  input wire logic [dmau_pkg::DMAU_PCW-1:0] PC_CUR,
  input wire dmau_pkg::dmau_tbl_t TBL_OP,
  input wire logic [dmau_pkg::DMAU_TBLW-1:0] PROG_WORD,
  output logic [dmau_pkg::DMAU_PCW-1:0] TBL_ADDR,
  output logic PC_JUMP,
  output logic [dmau_pkg::DMAU_PCW-1:0] PC_TARGET,
  output logic STALL,
  // State shown outward
  output logic [7:0] ACCUMULATOR,
  output logic [7:0] BANK_SELECT,
  output logic [7:0] NVM_CONTROL
);
  import dmau_pkg::*;

  logic [7:0] mem_pointer_a;
  logic [7:0] mem_pointer_b;
  logic [7:0] bank_select;
  logic [7:0] accumulator;
  logic [7:0] table_pointer;
  logic [7:0] table_high_latch;
  logic [7:0] bank1_nvm_control;
  logic [7:0] gp_mem [GP_SIZE];
  dmau_state_t state;
  dmau_state_t next_state;
  logic [7:0] tbl_low;
  logic tbl_pend;

  logic [6:0] eff_addr;
  logic eff_bank1;
  logic null_access;

  dmau_addr_map u_map (
    .addr(MEM_ADDR),
    .mptr_a(mem_pointer_a),
    .mptr_b(mem_pointer_b),
    .bank_select(bank_select),
    .eff_addr(eff_addr),
    .eff_bank1(eff_bank1),
    .null_access(null_access)
  );

  function automatic logic hit(input logic [6:0] a, input logic [6:0] r);
    hit = (a == r);
  endfunction

  wire live = ~null_access;
  wire wr_b0 = MEM_WR & live & ~eff_bank1;
  wire wr_nvm = MEM_WR & live & eff_bank1 & hit(eff_addr, DMAU_NVM_CTRL);
  // End bound one bit wider, since 40h plus 64 wraps to zero in seven bits
  wire [7:0] gp_end = 8'(int'(DMAU_GP_FIRST) + GP_SIZE);
  wire in_gp = (eff_addr >= DMAU_GP_FIRST) && ({1'b0, eff_addr} < gp_end);
  wire [5:0] gp_idx = 6'(eff_addr - DMAU_GP_FIRST);
  wire pcl_wr = wr_b0 & hit(eff_addr, DMAU_PCLOW);
  wire tbl_start = (TBL_OP != DMAU_TBL_NONE) & (state == DMAU_IDLE);
  wire [2:0] tbl_page = (TBL_OP == DMAU_TBL_LAST) ? DMAU_LAST_PAGE : PC_CUR[10:8];

  // Table low byte written to memory in the second table cycle
  wire tbl_wr = tbl_pend & (state == DMAU_BUSY);

  assign TBL_ADDR = {tbl_page, table_pointer};
  assign PC_JUMP = pcl_wr;
  assign PC_TARGET = {PC_CUR[10:8], MEM_WDATA};
  assign STALL = (state != DMAU_IDLE);
  assign ACCUMULATOR = accumulator;
  assign BANK_SELECT = bank_select;
  assign NVM_CONTROL = bank1_nvm_control;

  always_comb begin
    next_state = state;
    case (state)
      DMAU_IDLE: begin
        if (pcl_wr || tbl_start) begin
          next_state = DMAU_BUSY;
        end
      end
      DMAU_BUSY: next_state = DMAU_IDLE;
      default: next_state = DMAU_IDLE;
    endcase
  end

  logic [7:0] rd_val;
  always_comb begin
    rd_val = DMAU_ZERO;
    if (null_access) begin
      rd_val = DMAU_ZERO;
    end else if (eff_bank1) begin
      rd_val = hit(eff_addr, DMAU_NVM_CTRL) ? bank1_nvm_control : DMAU_ZERO;
    end else if (hit(eff_addr, DMAU_MPTR_A)) begin
      rd_val = mem_pointer_a | DMAU_MP_TOP;
    end else if (hit(eff_addr, DMAU_MPTR_B)) begin
      rd_val = mem_pointer_b | DMAU_MP_TOP;
    end else if (hit(eff_addr, DMAU_BANKSEL)) begin
      rd_val = bank_select;
    end else if (hit(eff_addr, DMAU_ACCUM)) begin
      rd_val = accumulator;
    end else if (hit(eff_addr, DMAU_PCLOW)) begin
      rd_val = PC_CUR[7:0];
    end else if (hit(eff_addr, DMAU_TPTR)) begin
      rd_val = table_pointer;
    end else if (hit(eff_addr, DMAU_THIGH)) begin
      rd_val = table_high_latch;
    end else if (in_gp) begin
      rd_val = gp_mem[gp_idx];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      MEM_RDATA <= DMAU_ZERO;
    end else if (MEM_RD) begin
      MEM_RDATA <= rd_val;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state <= DMAU_IDLE;
      tbl_pend <= 1'b0;
      tbl_low <= DMAU_ZERO;
      table_high_latch <= DMAU_ZERO;
    end else begin
      state <= next_state;
      tbl_pend <= tbl_start;
      if (tbl_start) begin
        // Upper bits of the program word; low byte held for the memory write
        table_high_latch <= 8'(PROG_WORD[DMAU_TBLW-1:8]);
        tbl_low <= PROG_WORD[7:0];
      end
    end
  end

  // Watchdog wake-up from power-down keeps the selected bank
  always_ff @(posedge SYS_CLK) begin
    if (RST && !WDT_PD_RESET) begin
      bank_select <= DMAU_BANK0;
    end else if (!RST && wr_b0 && hit(eff_addr, DMAU_BANKSEL)) begin
      bank_select <= MEM_WDATA;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      mem_pointer_a <= DMAU_MP_TOP;
      mem_pointer_b <= DMAU_MP_TOP;
      table_pointer <= DMAU_ZERO;
      accumulator <= DMAU_ZERO;
      bank1_nvm_control <= DMAU_ZERO;
    end else begin
      if (wr_b0 && hit(eff_addr, DMAU_MPTR_A)) begin
        mem_pointer_a <= MEM_WDATA | DMAU_MP_TOP;
      end
      if (wr_b0 && hit(eff_addr, DMAU_MPTR_B)) begin
        mem_pointer_b <= MEM_WDATA | DMAU_MP_TOP;
      end
      if (wr_b0 && hit(eff_addr, DMAU_TPTR)) begin
        table_pointer <= MEM_WDATA;
      end
      // ALU result takes priority over a memory write to the same register
      if (ALU_WR) begin
        accumulator <= ALU_RESULT;
      end else if (wr_b0 && hit(eff_addr, DMAU_ACCUM)) begin
        accumulator <= MEM_WDATA;
      end
      if (wr_nvm) begin
        bank1_nvm_control <= MEM_WDATA;
      end
    end
  end

  // Table write target latched with the instruction address at its first cycle
  logic [5:0] tbl_idx;
  logic tbl_idx_ok;
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      tbl_idx <= 6'h00;
      tbl_idx_ok <= 1'b0;
    end else if (tbl_start) begin
      tbl_idx <= gp_idx;
      tbl_idx_ok <= in_gp & live & ~eff_bank1;
    end
  end

  for (genvar i = 0; i < GP_SIZE; i++) begin : g_gp
    always_ff @(posedge SYS_CLK) begin
      if (tbl_wr && tbl_idx_ok && tbl_idx == 6'(i)) begin
        gp_mem[i] <= tbl_low;
      end else if (wr_b0 && in_gp && !tbl_start && gp_idx == 6'(i)) begin
        gp_mem[i] <= MEM_WDATA;
      end
    end
  end
endmodule
`default_nettype wire

// ### dmau_pkg.sv
// Behaviour
// - Special registers start at 00h; unused locations up to general memory read zero.
// - Indirect window access is redirected to the address in its paired pointer.
// - First window pair reaches bank zero only; second follows the bank selector.
// - Pointer aimed at a window location: indirect read gives zero, write does nothing.
// - Pointers are read/write registers; bit 7 always reads back as one.
// - Bank selector value 00 picks bank zero, 01 picks bank one.
// - Bank one holds only the nonvolatile control register at 40h, via second pair.
// - Resets return bank zero, except watchdog time-out reset during power-down.
// - Special register addresses map to bank zero whatever bank is selected.
// - Direct-address accesses always target bank zero.
// - ALU results go to the accumulator; register moves pass through it.
// - Writing program-counter low byte jumps within the current page.
// - Modifying program-counter low byte inserts one dummy cycle.
// - Table pointer is a normal register, set before a table read.
// - Table read latches high part in table high; low byte goes to memory.
// - Table address low byte from pointer; upper bits from PC or all ones.
// - Every table instruction takes two instruction cycles.
// - Table high register is read-only; writes are ignored.
package dmau_pkg;
  localparam int DMAU_AW = 8;
  localparam int DMAU_PCW = 11;
  localparam int DMAU_TBLW = 14;
  localparam logic [6:0] DMAU_IWIN_A = 7'h00;
  localparam logic [6:0] DMAU_MPTR_A = 7'h01;
  localparam logic [6:0] DMAU_IWIN_B = 7'h02;
  localparam logic [6:0] DMAU_MPTR_B = 7'h03;
  localparam logic [6:0] DMAU_BANKSEL = 7'h04;
  localparam logic [6:0] DMAU_ACCUM = 7'h05;
  localparam logic [6:0] DMAU_PCLOW = 7'h06;
  localparam logic [6:0] DMAU_TPTR = 7'h07;
  localparam logic [6:0] DMAU_THIGH = 7'h08;
  localparam logic [6:0] DMAU_SFR_LAST = 7'h1f;
  localparam logic [6:0] DMAU_GP_FIRST = 7'h40;
  localparam logic [6:0] DMAU_NVM_CTRL = 7'h40;
  localparam logic [7:0] DMAU_MP_TOP = 8'h80;
  localparam logic [7:0] DMAU_BANK0 = 8'h00;
  localparam logic [7:0] DMAU_BANK1 = 8'h01;
  localparam logic [7:0] DMAU_ZERO = 8'h00;
  localparam logic [2:0] DMAU_LAST_PAGE = 3'h7;
  localparam int DMAU_TBL_CYCLES = 2;
  localparam int DMAU_PCL_CYCLES = 2;
  typedef enum logic [1:0] {
    DMAU_IDLE = 2'b00,
    DMAU_BUSY = 2'b01,
    DMAU_WAIT = 2'b11
  } dmau_state_t;
  typedef enum logic [1:0] {
    DMAU_TBL_NONE = 2'b00,
    DMAU_TBL_CUR = 2'b01,
    DMAU_TBL_LAST = 2'b10
  } dmau_tbl_t;
endpackage

// ### dmau_prog_rom.sv
`timescale 1ns/1ps
`default_nettype none
// Program memory model; pattern makes page bits visible in each word
module dmau_prog_rom
  import dmau_pkg::*;
(
  // Table access
  input wire logic [dmau_pkg::DMAU_PCW-1:0] addr,
  output logic [dmau_pkg::DMAU_TBLW-1:0] word
);
  assign word = {addr[10:8], addr} ^ 14'h1a5c;
endmodule
`default_nettype wire
